// ### dv/ppgd_switch_model.sv
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------------
// primary switches and transformer core
// --------------------------------------------------------------------------
// the two switches on a centre-tapped primary; flux climbs while the first
// conducts and falls while the second does, so unequal widths creep
module ppgd_switch_model (
  input  wire logic clk,          // core clock
  input  wire logic gate_first,   // gate of first_output_switch
  input  wire logic gate_second,  // gate of second_output_switch
  output var  int   flux,         // net volt-time in cycles
  output var  int   shorts        // cycles with both switches on
);
  initial begin
    flux = 0;
    shorts = 0;
  end

  // both on shorts the primary ends, which a real stage would not survive
  always @(posedge clk) begin
    if (gate_first === 1'b1 && gate_second === 1'b1) begin
      shorts = shorts + 1;
    end
    flux = flux + int'(gate_first === 1'b1) - int'(gate_second === 1'b1);
  end
endmodule

`default_nettype wire

// ### dv/push_pull_gate_drive_gen_test.sv
`timescale 1ns/1ns
`default_nettype none

module push_pull_gate_drive_gen_test;
  localparam int HALF = int'(ppgd_pkg::HALF_A_CYC);
  localparam int DEAD = int'(ppgd_pkg::DEAD_A_CYC);
  localparam int HALF_B = int'(ppgd_pkg::HALF_B_CYC);
  localparam int DEAD_B = int'(ppgd_pkg::DEAD_B_CYC);
  logic                     core_clk;
  logic                     rst;
  logic                     drv_en;
  logic [ppgd_pkg::NCH-1:0] ch_data;
  logic                     gate_first;
  logic                     gate_second;
  logic [ppgd_pkg::NCH-1:0] ch_carrier;
  logic                     gate_first_b;
  logic                     gate_second_b;
  logic [ppgd_pkg::NCH-1:0] ch_carrier_b;
  int                       flux;
  int                       shorts;
  int                       err_count;
  int                       checks;
  int                       cyc;
  int                       rise [2];
  int                       fall [2];
  int                       nrise [2];
  logic                     prev [2];

  ppgd_gen #(.VARIANT_B(1'b0), .DEFAULT_HIGH(1'b1)) u_dut (
    .CORE_CLK(core_clk), .RST(rst), .DRV_EN(drv_en), .CH_DATA(ch_data),
    .GATE_FIRST(gate_first), .GATE_SECOND(gate_second), .CH_CARRIER(ch_carrier));

  // fast variant with a low default level, on the same stimulus
  ppgd_gen #(.VARIANT_B(1'b1), .DEFAULT_HIGH(1'b0)) u_dut_b (
    .CORE_CLK(core_clk), .RST(rst), .DRV_EN(drv_en), .CH_DATA(ch_data),
    .GATE_FIRST(gate_first_b), .GATE_SECOND(gate_second_b), .CH_CARRIER(ch_carrier_b));

  ppgd_switch_model u_sw (.clk(core_clk), .gate_first(gate_first),
    .gate_second(gate_second), .flux(flux), .shorts(shorts));

  // --------------------------------------------------------------------------
  // clock, edge log and hang guard
  // --------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // logs the cycle of every edge of gate_first and gate_second; a hang ends the run as a failure
  always @(posedge core_clk) begin : mon
    logic cur;
    cyc = cyc + 1;
    for (int k = 0; k < 2; k++) begin
      cur = k ? gate_second : gate_first;
      if (cur === 1'b1 && prev[k] !== 1'b1) begin
        rise[k] = cyc;
        nrise[k] = nrise[k] + 1;
      end
      if (cur !== 1'b1 && prev[k] === 1'b1) fall[k] = cyc;
      prev[k] = cur;
    end
    if (cyc > 8000) begin
      err_count++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // waits, bounded, for the next rise of gate k and returns just after the edge
  task automatic wait_rise(input int k);
    int n0;
    int t;
    n0 = nrise[k];
    t = 0;
    while (nrise[k] == n0 && t < 2000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    if (t >= 2000) err_count++;
  endtask

  task automatic wrap_up();
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  // two full periods from reset: widths, gaps, rate, flux and the sweep step
  task automatic t_gates();
    int f0;
    int r0;
    drv_en = 1'b1;
    wait_rise(0);
    f0 = flux;
    r0 = rise[0];
    wait_rise(1);
    check(fall[0] - rise[0], HALF - DEAD);
    check(rise[1] - fall[0], DEAD);
    check(rise[1] - rise[0], HALF);
    wait_rise(0);
    check(fall[1] - rise[1], HALF - DEAD);
    check(rise[0] - fall[1], DEAD);
    check(rise[0] - r0, 2 * HALF);
    check(flux, f0);
    r0 = rise[0];
    wait_rise(0);
    check(rise[0] - r0, 2 * HALF + 2);
    check(shorts, 0);
  endtask

  // drop the enable in mid pulse, then restart: first phase leads after a gap
  task automatic t_restart();
    int n1;
    int e;
    repeat (5) @(posedge core_clk);
    #1;
    drv_en = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check({gate_first, gate_second}, 0);
    n1 = nrise[1];
    e = cyc;
    drv_en = 1'b1;
    wait_rise(0);
    check(nrise[1] - n1, 0);
    check(rise[0] - e > DEAD, 1);
    check(shorts, 0);
  endtask

  // keyed channels carry two-high two-low, silent ones stay low
  task automatic t_carrier(input logic [ppgd_pkg::NCH-1:0] d);
    int hi [ppgd_pkg::NCH];
    int hb [ppgd_pkg::NCH];
    foreach (hi[i]) hi[i] = 0;
    foreach (hb[i]) hb[i] = 0;
    ch_data = d;
    repeat (3) @(posedge core_clk);
    repeat (8) begin
      @(posedge core_clk);
      #1;
      foreach (hi[i]) hi[i] += int'(ch_carrier[i] === 1'b1);
      foreach (hb[i]) hb[i] += int'(ch_carrier_b[i] === 1'b1);
    end
    foreach (hi[i]) check(hi[i], d[i] ? 0 : 4);
    foreach (hb[i]) check(hb[i], d[i] ? 4 : 0);
  endtask

  // reset in mid run with the enable held, then one fresh period of the fast variant
  task automatic t_reset_b();
    int t;
    int w [2];
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({gate_first, gate_second, gate_first_b, gate_second_b}, 0);
    t = 0;
    while (gate_first_b !== 1'b1 && t < 400) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    check(t, DEAD_B + 1);
    w[0] = 0;
    while (gate_first_b === 1'b1 && w[0] < 400) begin
      @(posedge core_clk);
      #1;
      w[0]++;
    end
    t = 0;
    while (gate_second_b !== 1'b1 && t < 400) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    check(t, DEAD_B);
    w[1] = 0;
    while (gate_second_b === 1'b1 && w[1] < 400) begin
      @(posedge core_clk);
      #1;
      w[1]++;
    end
    check(w[0], HALF_B - DEAD_B);
    check(w[1], HALF_B - DEAD_B);
  endtask

  initial begin
    rst = 1'b1;
    drv_en = 1'b0;
    ch_data = '1;
    err_count = 0;
    checks = 0;
    cyc = 0;
    prev = '{1'b0, 1'b0};
    nrise = '{0, 0};
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_gates();
    t_restart();
    t_carrier(4'h5);
    t_carrier(4'hA);
    t_carrier(4'h0);
    t_carrier(4'hF);
    t_reset_b();
    wrap_up();
  end
endmodule

`default_nettype wire

// ### rtl/ppgd_gen.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - The gate rate is the oscillator divided by two, one phase per oscillator cycle.
// - Two complementary gate outputs drive the switches alternately and are never high together.
// - A dead-time gap separates the end of one high pulse from the start of the other.
// - Both outputs stay low for a short interval before either one may go high.
// - Each data channel sends a carrier for one logic level and nothing for the other.
// - The high pulses of both phases have exactly the same length.
// - The switching clock is modulated so emissions spread over several frequencies.
module ppgd_gen #(
  parameter bit VARIANT_B    = 1'b0,                 // 0: slow variant, 1: fast variant
  parameter bit DEFAULT_HIGH = 1'b1                  // channel default output level
) (
  input  wire logic                     CORE_CLK,     // core clock, 100 MHz
  input  wire logic                     RST,          // synchronous reset, active high
  input  wire logic                     DRV_EN,       // transformer drive enable
  input  wire logic [ppgd_pkg::NCH-1:0] CH_DATA,      // channel logic inputs
  output logic                          GATE_FIRST,   // gate of first_output_switch
  output logic                          GATE_SECOND,  // gate of second_output_switch
  output logic [ppgd_pkg::NCH-1:0]      CH_CARRIER    // carrier_on_off_keying outputs
);

  // ---------------------------------------------------------------------------
  // variant selection
  // ---------------------------------------------------------------------------
  localparam logic [9:0] NOMINAL  = VARIANT_B ? ppgd_pkg::HALF_B_CYC
                                              : ppgd_pkg::HALF_A_CYC;
  localparam logic [9:0] DEAD_CYC = VARIANT_B ? ppgd_pkg::DEAD_B_CYC
                                              : ppgd_pkg::DEAD_A_CYC;
  localparam logic [ppgd_pkg::NCH-1:0] DEF_MASK = {ppgd_pkg::NCH{DEFAULT_HIGH}};

  logic       run;
  logic       phase;
  logic [9:0] pos;
  logic [9:0] half_len;
  logic       osc_tick;
  logic       ss_step;

  // ---------------------------------------------------------------------------
  // oscillator and divide by two
  // ---------------------------------------------------------------------------
  // enable is registered so stop and restart act on a clean cycle boundary
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      run <= 1'b0;
    end else begin
      run <= DRV_EN;
    end
  end

  assign osc_tick = run && (pos == half_len - 10'h001);
  // the sweep only moves after the second phase, so both halves of a period
  // share one length
  assign ss_step  = osc_tick && phase;

  ppgd_spread #(
    .NOMINAL (NOMINAL)
  ) u_spread (
    .clk      (CORE_CLK),
    .rst      (RST),
    .step     (ss_step),
    .half_len (half_len)
  );

  // position inside the current oscillator cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST || !run) begin
      pos <= 10'h000;
    end else if (osc_tick) begin
      pos <= 10'h000;
    end else begin
      pos <= pos + 10'h001;
    end
  end

  // phase flips once per oscillator cycle, giving half the oscillator rate
  always_ff @(posedge CORE_CLK) begin
    if (RST || !run) begin
      phase <= 1'b0;
    end else if (osc_tick) begin
      phase <= ~phase;
    end
  end

  // ---------------------------------------------------------------------------
  // dead_time_gap_logic and gate outputs
  // ---------------------------------------------------------------------------
  // every half opens with the gap, including the first half after enable, so
  // restart never shorts the primary ends
  always_ff @(posedge CORE_CLK) begin
    if (RST || !run) begin
      GATE_FIRST  <= 1'b0;
      GATE_SECOND <= 1'b0;
    end else if (osc_tick) begin
      GATE_FIRST  <= 1'b0;
      GATE_SECOND <= 1'b0;
    end else if (pos == DEAD_CYC - 10'h001) begin
      GATE_FIRST  <= ~phase;
      GATE_SECOND <= phase;
    end
  end

  // ---------------------------------------------------------------------------
  // carrier_on_off_keying transmit
  // ---------------------------------------------------------------------------
  logic [1:0] car_cnt;
  logic       car_level;
  logic [ppgd_pkg::NCH-1:0] want;

  // the default level maps to silence, so a lost carrier reads as default
  assign want = CH_DATA ^ DEF_MASK;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      car_cnt   <= 2'h0;
      car_level <= 1'b0;
    end else if (car_cnt == ppgd_pkg::CAR_HALF_CYC - 2'h1) begin
      car_cnt   <= 2'h0;
      car_level <= ~car_level;
    end else begin
      car_cnt <= car_cnt + 2'h1;
    end
  end

  // one keyed output flop per channel
  genvar ch;
  generate
    for (ch = 0; ch < ppgd_pkg::NCH; ch++) begin : g_ch
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          CH_CARRIER[ch] <= 1'b0;
        end else begin
          CH_CARRIER[ch] <= want[ch] & car_level;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic [9:0] low_cnt;
  logic [9:0] hi_first;
  logic [9:0] hi_second;
  logic [9:0] last_first;

  // helper: cycles both gates have been low, and high widths per phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      low_cnt    <= 10'h000;
      hi_first   <= 10'h000;
      hi_second  <= 10'h000;
      last_first <= 10'h000;
    end else begin
      // saturates, so a long idle cannot wrap round and fake a short gap
      low_cnt   <= (GATE_FIRST || GATE_SECOND) ? 10'h000
                 : low_cnt + {9'h000, (low_cnt != 10'h3FF)};
      hi_first  <= GATE_FIRST ? hi_first + 10'h001 : 10'h000;
      hi_second <= GATE_SECOND ? hi_second + 10'h001 : 10'h000;
      if (!run) begin
        last_first <= 10'h000;
      end else if (!GATE_FIRST && hi_first != 10'h000) begin
        last_first <= hi_first;
      end
    end
  end

  no_overlap_a: assert property (!(GATE_FIRST && GATE_SECOND))
    else $error("both gates high");

  dead_gap_a: assert property (
    ($rose(GATE_FIRST) || $rose(GATE_SECOND)) |-> $past(low_cnt) >= DEAD_CYC - 10'h001)
    else $error("dead gap too short");

  start_low_a: assert property ($rose(run) |-> (!GATE_FIRST && !GATE_SECOND) [*8])
    else $error("gate high right after enable");

  phase_div_a: assert property (
    osc_tick |=> (phase != $past(phase)) && !GATE_FIRST && !GATE_SECOND)
    else $error("phase did not flip on oscillator tick");

  alt_phase_a: assert property (
    $rose(GATE_FIRST) |-> !phase && $past(pos) == DEAD_CYC - 10'h001)
    else $error("first gate rose in wrong phase");

  equal_width_a: assert property (
    $fell(GATE_SECOND) && $past(run) && last_first != 10'h000
      |-> $past(hi_second) + 10'h001 == last_first)
    else $error("phase high widths differ");

  hold_len_a: assert property (
    (osc_tick && !phase) |=> $stable(half_len))
    else $error("length changed inside a period");

  sweep_range_a: assert property (
    half_len <= NOMINAL + ppgd_pkg::SS_SPAN && half_len >= NOMINAL - ppgd_pkg::SS_SPAN)
    else $error("half period outside sweep range");

  sweep_moves_a: assert property (
    ss_step |=> ##1 half_len != $past(half_len, 2))
    else $error("sweep did not move");

  keying_a: assert property (
    (CH_CARRIER & ~$past(want)) == {ppgd_pkg::NCH{1'b0}})
    else $error("carrier sent for default level");

  keying_on_a: assert property (
    (want[0] [*4]) |-> (CH_CARRIER[0] || $past(CH_CARRIER[0]) || $past(CH_CARRIER[0], 2)))
    else $error("no carrier for active level");

  first_pulse_c:  cover property ($fell(GATE_FIRST) ##[1:40] $rose(GATE_SECOND));
  restart_c:      cover property ($fell(run) ##[1:20] $rose(run));
  sweep_turn_c:   cover property (ss_step && half_len == NOMINAL + ppgd_pkg::SS_SPAN);
  carrier_c:      cover property ($rose(CH_CARRIER[1]));

endmodule

`default_nettype wire

// ### rtl/ppgd_pkg.sv
package ppgd_pkg;

  // --------------------------------------------------------------------------
  // clock and timing figures
  // --------------------------------------------------------------------------
  localparam int CLK_HZ       = 100000000;  // core clock rate
  localparam int FSW_A_HZ     = 160000;     // nominal switching rate, variant a
  localparam int FSW_B_HZ     = 424000;     // nominal switching rate, variant b
  localparam int DEAD_A_NS    = 115;        // break-before-make time, variant a
  localparam int DEAD_B_NS    = 90;         // break-before-make time, variant b
  localparam int CARRIER_HZ   = 25000000;   // on-off keying carrier rate

  // --------------------------------------------------------------------------
  // derived cycle counts
  // --------------------------------------------------------------------------
  localparam int LEN_W        = 10;         // width of half-period counters
  // half period is one oscillator cycle; the gate period is two of them
  localparam logic [9:0] HALF_A_CYC = 10'(CLK_HZ / (2 * FSW_A_HZ));
  localparam logic [9:0] HALF_B_CYC = 10'(CLK_HZ / (2 * FSW_B_HZ));
  // a least time, so round up
  localparam logic [9:0] DEAD_A_CYC = 10'((DEAD_A_NS * (CLK_HZ / 1000000) + 999) / 1000);
  localparam logic [9:0] DEAD_B_CYC = 10'((DEAD_B_NS * (CLK_HZ / 1000000) + 999) / 1000);
  localparam logic [1:0] CAR_HALF_CYC = 2'(CLK_HZ / (2 * CARRIER_HZ));

  // --------------------------------------------------------------------------
  // spread spectrum sweep
  // --------------------------------------------------------------------------
  localparam logic [9:0] SS_SPAN  = 10'h008;  // sweep depth in cycles each way
  localparam logic [9:0] LEN_RST  = 10'h000;  // offset after reset

  localparam int NCH = 4;                     // data channels

endpackage

// ### rtl/ppgd_spread.sv
`timescale 1ns/1ns
`default_nettype none

// triangle sweep of the oscillator half period; the length only moves on a
// step pulse, which the caller gives once per full gate period
module ppgd_spread #(
  parameter logic [9:0] NOMINAL = 10'h100        // nominal half period in cycles
) (
  input  wire logic       clk,                   // core clock
  input  wire logic       rst,                   // synchronous reset
  input  wire logic       step,                  // one-cycle pulse, advance sweep
  output logic      [9:0] half_len               // current half period length
);

  logic [9:0] offset;
  logic       going_up;

  // ---------------------------------------------------------------------------
  // sweep state
  // ---------------------------------------------------------------------------
  // a triangle keeps neighbouring periods close, so the flux walk stays small
  always_ff @(posedge clk) begin
    if (rst) begin
      offset   <= ppgd_pkg::LEN_RST;
      going_up <= 1'b1;
    end else if (step) begin
      if (going_up) begin
        if (offset == ppgd_pkg::SS_SPAN) begin
          going_up <= 1'b0;
          offset   <= offset - 10'h001;
        end else begin
          offset <= offset + 10'h001;
        end
      end else begin
        if (offset == (10'h000 - ppgd_pkg::SS_SPAN)) begin
          going_up <= 1'b1;
          offset   <= offset + 10'h001;
        end else begin
          offset <= offset - 10'h001;
        end
      end
    end
  end

  // length is a flop so it can only change with the sweep step
  always_ff @(posedge clk) begin
    if (rst) begin
      half_len <= NOMINAL;
    end else begin
      half_len <= NOMINAL + offset;
    end
  end

endmodule

`default_nettype wire
